// ===== rtl/brd_pkg.sv
// Constants and carrier types for the boot RAM download handler
package brd_pkg;

  // Command and acknowledge codes
  localparam logic [7:0] CMD_DOWNLOAD = 8'h10;
  localparam logic [7:0] ACK_OK = 8'h10;
  localparam logic [7:0] PW_BLANK = 8'hFF;
  localparam logic [3:0] ACK_LO_RXERR = 4'h8;
  localparam logic [3:0] ACK_LO_BAD = 4'h1;
  // Error acks in the download phases carry the download command's nibble
  localparam logic [3:0] ACK_HI_DL = CMD_DOWNLOAD[7:4];
  localparam logic [3:0] HI_RESET = 4'hF;

  // Phase lengths: password and address byte counts, and index of the checksum byte within each phase
  localparam int PW_LEN = 12;
  localparam logic [3:0] PW_LAST = 4'hC;
  localparam logic [3:0] ADR_LAST = 4'h6;
  localparam logic [3:0] ADR_BYTES = 4'h4;

  // Permitted load window in on-chip RAM
  localparam logic [31:0] RAM_LO = 32'hFFFD_6000;
  localparam logic [31:0] RAM_HI = 32'hFFFD_EFFF;

  typedef enum logic [8:0] {
    S_CMD = 9'h001,
    S_PW  = 9'h002,
    S_ADR = 9'h004,
    S_DAT = 9'h008,
    S_EVP = 9'h010,
    S_EVA = 9'h020,
    S_EVD = 9'h040,
    S_ACK = 9'h080,
    S_JMP = 9'h100
  } brd_state_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } brd_rx_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] data;
  } brd_ram_t;

  typedef struct packed {
    logic go;
    logic isa32;
    logic [31:0] addr;
  } brd_jump_t;

endpackage

// ===== rtl/brd_sum8.sv
// Running eight-bit modular checksum accumulator
module brd_sum8
  import brd_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic add,
  input wire logic [W-1:0] din,
  // Result
  output logic [W-1:0] sum,
  output logic zero
);

  logic [W-1:0] sum_q;
  logic [W-1:0] sum_d;

  // Carry drops by width truncation
  assign sum_d = clr ? '0 : (add ? W'(sum_q + din) : sum_q);
  assign sum = sum_q;
  assign zero = (sum_q == '0);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sum_q <= '0;
    else
      sum_q <= sum_d;
  end

endmodule

// ===== rtl/brd_download.sv
// Boot RAM download handler: password, address phase, payload store, branch
module brd_download
  import brd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Channel mode
  input wire logic clocked_mode,
  // Received bytes
  input wire brd_rx_t rx,
  output logic rx_ready,
  // Acknowledge bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Stored password
  input wire logic [PW_LEN*8-1:0] pw_stored,
  // RAM write port and branch request
  output brd_ram_t ram_wr,
  output brd_jump_t jump,
  // Command byte not handled here
  output logic other_cmd
);
  brd_state_t st_q;
  brd_state_t st_d;
  brd_state_t after_q;
  brd_state_t after_d;
  logic load_ack;
  logic [7:0] ack_d;
  logic [3:0] cnt_q;
  logic [31:0] addr_q;
  logic [15:0] rem_q;
  logic [31:0] ptr_q;
  logic pw_mis_q;
  logic rxe_q;
  logic [3:0] last_hi_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic rx_ready_q;
  brd_ram_t ram_q;
  brd_jump_t jump_q;
  logic other_q;
  logic from_cmd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire rx_take = rx.valid && rx_ready_q;
  wire ack_done = (st_q == S_ACK) && tx_ready;
  wire phase_start = ack_done && (after_q == S_PW || after_q == S_ADR || after_q == S_DAT);
  wire cmd_is_dl = (rx.data == CMD_DOWNLOAD);
  // receive errors ignored when the channel is clocked
  wire rx_err_seen = rx.err && !clocked_mode;
  wire in_pw = (st_q == S_PW);
  wire in_adr = (st_q == S_ADR);
  wire in_dat = (st_q == S_DAT);
  wire add_byte = rx_take && (in_pw || in_adr || in_dat);
  wire pay_byte = rx_take && in_dat && (rem_q != 16'h0000);
  wire [7:0] pw_exp = pw_stored[{cnt_q, 3'b000} +: 8];
  wire pw_byte_bad = rx_take && in_pw && (cnt_q < PW_LAST) && (rx.data != pw_exp);
  wire sum_zero;
  // uniform stored password other than blank is refused
  logic [PW_LEN-1:0] pw_eq;
  generate
    for (genvar gi = 0; gi < PW_LEN; gi++)
    begin : g_eq
      assign pw_eq[gi] = (pw_stored[gi*8 +: 8] == pw_stored[7:0]);
    end
  endgenerate
  wire pw_uniform = (&pw_eq) && (pw_stored[7:0] != PW_BLANK);
  wire pw_err = pw_mis_q || pw_uniform;
  // only the start address is checked against the window
  wire in_win = (addr_q >= RAM_LO) && (addr_q <= RAM_HI);
  // acknowledge codes built from fixed nibbles
  wire [7:0] ack_rx = {ACK_HI_DL, ACK_LO_RXERR};
  wire [7:0] ack_bad = {ACK_HI_DL, ACK_LO_BAD};
  // receive error first, sum next, password or address window last, pass
  wire [7:0] ack_pw = rxe_q ? ack_rx : (!sum_zero || pw_err) ? ack_bad : ACK_OK;
  wire [7:0] ack_adr = rxe_q ? ack_rx : (!sum_zero || !in_win) ? ack_bad : ACK_OK;
  wire [7:0] ack_dat = rxe_q ? ack_rx : !sum_zero ? ack_bad : ACK_OK;
  // one accumulator, cleared at each checked phase
  brd_sum8 #(
    .W(8)
  ) u_sum (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(phase_start),
    .add(add_byte),
    .din(rx.data),
    .sum(),
    .zero(sum_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    st_d = st_q;
    after_d = after_q;
    load_ack = 1'b0;
    ack_d = ACK_OK;
    case (st_q)
      S_CMD:
      begin
        // download command echoed, error nibble from last command
        if (rx_take && cmd_is_dl)
        begin
          load_ack = 1'b1;
          st_d = S_ACK;
          ack_d = rx_err_seen ? {last_hi_q, ACK_LO_RXERR} : ACK_OK;
          after_d = rx_err_seen ? S_CMD : S_PW;
        end
      end
      S_PW:
        if (rx_take && cnt_q == PW_LAST)
          st_d = S_EVP;
      S_ADR:
        if (rx_take && cnt_q == ADR_LAST)
          st_d = S_EVA;
      S_DAT:
        if (rx_take && rem_q == 16'h0000)
          st_d = S_EVD;
      S_EVP:
      begin
        load_ack = 1'b1;
        ack_d = ack_pw;
        st_d = S_ACK;
        after_d = (ack_pw == ACK_OK) ? S_ADR : S_CMD;
      end
      S_EVA:
      begin
        load_ack = 1'b1;
        ack_d = ack_adr;
        st_d = S_ACK;
        after_d = (ack_adr == ACK_OK) ? S_DAT : S_CMD;
      end
      S_EVD:
      begin
        load_ack = 1'b1;
        ack_d = ack_dat;
        st_d = S_ACK;
        // only a normal final ack leads to the branch
        after_d = (ack_dat == ACK_OK) ? S_JMP : S_CMD;
      end
      S_ACK:
        if (tx_ready)
          st_d = after_q;
      S_JMP:
        st_d = S_CMD;
      default:
        st_d = S_CMD;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= S_CMD;
      after_q <= S_CMD;
      rx_ready_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      after_q <= after_d;
      rx_ready_q <= (st_d == S_CMD) || (st_d == S_PW) || (st_d == S_ADR) || (st_d == S_DAT);
    end
  end

  // Held until the transmitter takes it; no byte is dropped under stall
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= ACK_OK;
      from_cmd_q <= 1'b0;
    end
    else if (load_ack)
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= ack_d;
      from_cmd_q <= (st_q == S_CMD);
    end
    else if (ack_done)
      tx_valid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase data
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= 4'h0;
      pw_mis_q <= 1'b0;
      rxe_q <= 1'b0;
    end
    else if (phase_start)
    begin
      cnt_q <= 4'h0;
      pw_mis_q <= 1'b0;
      rxe_q <= 1'b0;
    end
    else if (add_byte)
    begin
      cnt_q <= cnt_q + 4'h1;
      pw_mis_q <= pw_mis_q || pw_byte_bad;
      rxe_q <= rxe_q || rx_err_seen;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      last_hi_q <= HI_RESET;
    else if (rx_take && st_q == S_CMD && !rx_err_seen)
      last_hi_q <= rx.data[7:4];
  end

  // address and count shifted in MSB first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      addr_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
    end
    else if (rx_take && in_adr && cnt_q < ADR_BYTES)
      addr_q <= {addr_q[23:0], rx.data};
    else if (rx_take && in_adr && cnt_q < ADR_LAST)
      rem_q <= {rem_q[7:0], rx.data};
    else if (pay_byte)
      rem_q <= rem_q - 16'h0001;
  end

  // sequential store of exactly the counted bytes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ptr_q <= 32'h0000_0000;
      ram_q <= '0;
    end
    else
    begin
      ram_q.we <= pay_byte;
      ram_q.addr <= ptr_q;
      ram_q.data <= rx.data;
      if (phase_start && after_q == S_DAT)
        ptr_q <= addr_q;
      else if (pay_byte)
        ptr_q <= ptr_q + 32'h0000_0001;
    end
  end

  // branch request in 32-bit instruction mode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      jump_q <= '0;
      other_q <= 1'b0;
    end
    else
    begin
      jump_q.go <= (st_q == S_JMP);
      jump_q.isa32 <= 1'b1;
      jump_q.addr <= addr_q;
      other_q <= rx_take && st_q == S_CMD && !cmd_is_dl;
    end
  end
  assign rx_ready = rx_ready_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign ram_wr = ram_q;
  assign jump = jump_q;
  assign other_cmd = other_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_bits_a: assert property (tx_valid_q |-> tx_data_q[2:1] == 2'b00)
    else $error("ack bits 2:1 not zero");
  no_rxerr_a: assert property (clocked_mode && tx_valid_q |-> !tx_data_q[3])
    else $error("receive error ack in clocked mode");
  rx_first_a: assert property ((st_q == S_EVP) && rxe_q |=> tx_data_q == 8'h18)
    else $error("password receive error not 18H");
  pw_refuse_a: assert property ((st_q == S_EVP) && !rxe_q && pw_err |=> tx_data_q == 8'h11)
    else $error("password error not 11H");
  pw_sum_a: assert property ((st_q == S_EVP) && !rxe_q && !sum_zero |=> tx_data_q == 8'h11)
    else $error("password checksum error not 11H");
  adr_win_a: assert property ((st_q == S_EVA) && !rxe_q && !in_win |=> tx_data_q == 8'h11)
    else $error("address outside window accepted");
  err_hi_a: assert property (tx_valid_q && !from_cmd_q && tx_data_q != ACK_OK |-> tx_data_q[7:4] == ACK_HI_DL)
    else $error("error ack upper nibble wrong");
  err_back_a: assert property (ack_done && tx_data_q != ACK_OK |=> st_q == S_CMD)
    else $error("error ack did not return to command wait");
  ram_stop_a: assert property (rx_take && in_dat && rem_q == 16'h0000 |=> !ram_q.we ##1 !ram_q.we)
    else $error("checksum byte written to RAM");
  jump_ok_a: assert property ($rose(jump_q.go) |-> $past(tx_data_q, 2) == ACK_OK && jump_q.addr == addr_q)
    else $error("branch without normal final ack");
  pw_pass_a: assert property ((st_q == S_EVP) && !rxe_q && sum_zero && !pw_err |=> tx_data_q == 8'h10 ##1 1)
    else $error("good password not acked 10H");
  jump_c: cover property ($rose(jump_q.go));
  pw_bad_c: cover property ((st_q == S_EVP) && pw_err);
  rxerr_c: cover property (tx_valid_q && tx_data_q == 8'h18);
  win_c: cover property ((st_q == S_EVA) && !in_win);

endmodule

// ===== testbench/brd_host_model.sv
// Host controller model driving the boot serial channel
module brd_host_model
  import brd_pkg::*;
(
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic slow,
  // Bytes towards the block
  output brd_rx_t rx,
  input wire logic rx_ready,
  // Acknowledges from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] acks[$];
  logic ph;
  initial
  begin
    rx = '0;
    tx_ready = 1'b0;
    ph = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Slow host takes acks only every other cycle
  always @(negedge clk_sys)
  begin
    ph <= ~ph;
    tx_ready <= ~slow | ph;
  end
  always @(posedge clk_sys)
    if (tx_valid && tx_ready)
      acks.push_back(tx_data);
  ////////////////////////////////////////////////////////////
  // two's complement checksum
  task automatic send(input logic [7:0] q[$], input logic ck, input logic [7:0] d, input int e);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i])
      s += q[i];
    if (ck)
      q.push_back(8'h00 - s + d);
    foreach (q[i])
    begin
      rx = '{valid: 1'b1, err: (i == e), data: q[i]};
      do
        @(posedge clk_sys);
      while (rx_ready !== 1'b1);
      @(negedge clk_sys);
    end
    // Released line shows the inverse, not a stale byte
    rx = '{valid: 1'b0, err: 1'b0, data: ~q[q.size()-1]};
  endtask
endmodule

// ===== testbench/boot_ram_download_handler_test.sv
// Self-checking bench for the boot RAM download handler
module boot_ram_download_handler_test
  import brd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] brd_bytes_t[$];
  localparam logic [95:0] PW0 = 96'h0123_4567_89ab_cdef_1357_9bdf;
  logic clk_sys, rst, clocked_mode, slow, rx_ready, tx_valid, tx_ready, other_cmd;
  logic [7:0] tx_data;
  logic [95:0] pw_stored;
  brd_rx_t rx;
  brd_ram_t ram_wr;
  brd_jump_t jump;
  int fail_count = 0, check_count = 0, cyc = 0, oc = 0;
  brd_ram_t wq[$];
  brd_jump_t jq[$];

  brd_download DUT (.clk_sys(clk_sys), .rst(rst), .clocked_mode(clocked_mode), .rx(rx), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .pw_stored(pw_stored), .ram_wr(ram_wr),
    .jump(jump), .other_cmd(other_cmd));
  brd_host_model h (.clk_sys(clk_sys), .slow(slow), .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc++;
    if (ram_wr.we === 1'b1)
      wq.push_back(ram_wr);
    if (jump.go === 1'b1)
      jq.push_back(jump);
    if (other_cmd === 1'b1)
      oc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [40:0] got, input logic [40:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic brd_bytes_t bq(input logic [7:0] b);
    return {b};
  endfunction
  function automatic brd_bytes_t adr(input logic [31:0] a, input logic [15:0] c);
    return {a[31:24], a[23:16], a[15:8], a[7:0], c[15:8], c[7:0]};
  endfunction
  function automatic brd_bytes_t pw();
    brd_bytes_t q;
    for (int k = 0; k < 12; k++)
      q.push_back(pw_stored[8*k +: 8]);
    return q;
  endfunction
  // Send one phase and judge the single ack it earns
  task automatic phase(input brd_bytes_t q, input logic ck, input logic [7:0] d, input int e, input logic [7:0] x);
    int n;
    h.send(q, ck, d, e);
    n = 0;
    while (h.acks.size() == 0 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(h.acks.size() ? h.acks.pop_front() : 8'hxx, x);
  endtask
  task automatic login(input brd_bytes_t q, input logic [7:0] d, input int e, input logic [7:0] x);
    phase(bq(CMD_DOWNLOAD), 0, 0, -1, ACK_OK);
    phase(q, 1, d, e, x);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_ok(input logic [31:0] a, input logic [15:0] c, input logic s);
    brd_bytes_t p;
    slow = s;
    wq.delete();
    jq.delete();
    login(pw(), 0, -1, 8'h10);
    phase(adr(a, c), 1, 0, -1, 8'h10);
    for (int i = 0; i < c; i++)
      p.push_back(8'h31 + 8'(i * 7));
    phase(p, 1, 0, -1, 8'h10);
    repeat (4) @(negedge clk_sys);
    check(wq.size(), c);
    foreach (wq[i])
      check(wq[i], {1'b1, a + i, p[i]});
    check(jq.size() ? jq[0] : 'x, {2'b11, a});
    slow = 1'b0;
  endtask
  task automatic t_pw();
    brd_bytes_t q;
    q = pw();
    q[11] = ~q[11];
    login(q, 0, -1, 8'h11);
    login(pw(), 1, -1, 8'h11);
    login(pw(), 0, 3, 8'h18);
    clocked_mode = 1'b1;
    login(pw(), 0, 3, 8'h10);
    phase(adr(RAM_LO - 1, 1), 1, 0, 5, 8'h11);
    clocked_mode = 1'b0;
  endtask
  task automatic t_adr();
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_LO, 1), 1, 1, -1, 8'h11);
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_LO, 1), 1, 0, 6, 8'h18);
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_HI + 1, 1), 1, 0, -1, 8'h11);
  endtask
  task automatic t_pl();
    brd_bytes_t e;
    jq.delete();
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_LO, 12), 1, 0, -1, 8'h10);
    phase(pw(), 1, 1, -1, 8'h11);
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_LO, 12), 1, 0, -1, 8'h10);
    phase(pw(), 1, 0, 0, 8'h18);
    repeat (4) @(negedge clk_sys);
    check(jq.size(), 0);
    wq.delete();
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_HI, 0), 1, 0, -1, 8'h10);
    phase(e, 1, 0, -1, 8'h10);
    repeat (4) @(negedge clk_sys);
    check(wq.size(), 0);
    check(jq.size() ? jq[0] : 'x, {2'b11, RAM_HI});
  endtask
  task automatic t_uni();
    pw_stored = {12{8'h55}};
    login(pw(), 0, -1, 8'h11);
    pw_stored = {12{8'hff}};
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_HI + 1, 0), 1, 0, -1, 8'h11);
    pw_stored = PW0;
  endtask
  task automatic t_cmd();
    oc = 0;
    h.send(bq(8'h20), 0, 0, -1);
    repeat (3) @(negedge clk_sys);
    check(oc, 1);
    phase(bq(8'h10), 0, 0, 0, 8'h28);
    login(pw(), 0, -1, 8'h10);
    phase(adr(RAM_HI + 1, 0), 1, 0, -1, 8'h11);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    clocked_mode = 1'b0;
    slow = 1'b0;
    pw_stored = PW0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_ok(RAM_LO, 16'h0003, 1'b0);
    t_ok(RAM_HI, 16'h0001, 1'b1);
    t_pw();
    t_adr();
    t_pl();
    t_uni();
    t_cmd();
    finish_test();
  end
endmodule
